// file: logic/wms_pkg.sv
// constants, register map and carrier types of the warning mask and signal selector
package wms_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] REG_MASK_CMD  = 8'h00;
	localparam logic [7:0] REG_MASK      = 8'h04;
	localparam logic [7:0] REG_COND      = 8'h08;
	localparam logic [7:0] REG_UDC_REF   = 8'h0C;
	localparam logic [7:0] REG_MFI_MODE  = 8'h10;
	localparam logic [7:0] REG_CONFIG    = 8'h14;
	localparam logic [7:0] REG_REMOTE    = 8'h18;
	localparam logic [7:0] REG_IRQ_STAT  = 8'h1C;
	localparam logic [7:0] REG_IRQ_MASK  = 8'h20;
	localparam logic [7:0] REG_SEL_OUT   = 8'h24;
	localparam logic [7:0] REG_SEL_BASE  = 8'h30;

	////////////////////////////////////////////////////////////////////////
	// mask configuration codes
	localparam logic [7:0] CMD_NONE      = 8'h00;
	localparam logic [7:0] CMD_ALL       = 8'h01;
	localparam logic [7:0] CMD_WARN      = 8'h02;
	localparam logic [7:0] CMD_CTRL      = 8'h03;
	localparam logic [7:0] CMD_REMOVE    = 8'h64;
	localparam logic [7:0] CMD_RM_LO     = 8'h65;
	localparam logic [7:0] CMD_RM_HI     = 8'h8F;
	localparam logic [7:0] WARN_LO       = 8'h0A;
	localparam logic [7:0] WARN_HI       = 8'h19;
	localparam logic [7:0] CST_LO        = 8'h1E;
	localparam logic [7:0] CST_HI        = 8'h20;
	localparam logic [7:0] CST_BUS_VOLTAGE_LIMIT_STATE     = 8'h21;
	localparam logic [7:0] CLIM_LO       = 8'h22;
	localparam logic [7:0] CLIM_HI       = 8'h2B;
	localparam logic [4:0] BIT_CST_LO    = 5'h10;
	localparam logic [4:0] BIT_BUS_VOLTAGE_LIMIT_STATE     = 5'h1F;
	localparam logic [4:0] BIT_CLIM_LO   = 5'h14;
	localparam logic [31:0] BULK_ALL     = 32'hFFFF_FFFF;
	localparam logic [31:0] BULK_WARN    = 32'h0000_FFFF;
	localparam logic [31:0] BULK_CTRL    = 32'hFFFF_0000;
	localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// signal source selection codes
	localparam int          NUM_SEL      = 4;
	localparam logic [8:0]  SRC_ON       = 9'h006;
	localparam logic [8:0]  SRC_OFF      = 9'h007;
	localparam logic [8:0]  SRC_TECH     = 9'h00D;
	localparam logic [8:0]  SRC_FAULT    = 9'h03D;
	localparam logic [8:0]  SRC_TERM1    = 9'h046;
	localparam logic [8:0]  SRC_TERM6    = 9'h04B;
	localparam logic [8:0]  SRC_MFI      = 9'h04C;
	localparam logic [8:0]  SRC_MASK     = 9'h09D;
	localparam logic [8:0]  SEL_RESET    = 9'h007;
	localparam logic [2:0]  MFI_DIGITAL  = 3'h3;
	localparam logic [9:0]  CFG_TECH_A   = 10'h06F;
	localparam logic [9:0]  CFG_TECH_B   = 10'h19B;
	localparam logic [9:0]  CFG_RESET    = 10'h06E;
	localparam logic [15:0] UDC_REF_RST  = 16'hFFFF;

	////////////////////////////////////////////////////////////////////////
	// interrupt status bits
	localparam int          IRQ_HIT      = 0;
	localparam int          IRQ_FAULT    = 1;

	// live conditions from the drive, all on sys_clk
	typedef struct packed {
		logic [15:0] warn;
		logic        bus_voltage_dynamic_state;
		logic        mains_loss_shutdown_state;
		logic        mains_loss_regulation_state;
		logic        boost;
		logic        current_limited;
		logic        torque_limited;
		logic        torque_ctrl;
		logic        ramp_stop;
		logic        long_overload_reached;
		logic        short_overload_reached;
		logic        icl_active;
		logic        heatsink_limit;
		logic        motor_temp_limit;
		logic        freq_limit;
	} wms_cond_t;

endpackage : wms_pkg

// file: logic/wms_top.sv
// warning mask aggregation and digital source selection with apb registers
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps

module wms_top
	import wms_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [5:0]          terminal_input,
	input  wire logic                multifunction_input_digital,
	input  wire wms_cond_t           conds,
	input  wire logic [15:0]         bus_voltage,
	input  wire logic                fault,
	input  wire logic                tech_start,
	output logic      [NUM_SEL-1:0]  func_out,
	output logic                     ctrl_release,
	output logic                     mask_hit,
	output logic                     irq
);

	////////////////////////////////////////////////////////////////////////
	// code to mask bit weight
	function automatic logic [31:0] code_to_bit(input logic [7:0] code);
		logic [31:0] b;
		b = '0;
		if (code >= WARN_LO && code <= WARN_HI)
			b[5'(code - WARN_LO)] = 1'b1;
		else if (code >= CST_LO && code <= CST_HI)
			b[BIT_CST_LO + 5'(code - CST_LO)] = 1'b1;
		else if (code == CST_BUS_VOLTAGE_LIMIT_STATE)
			b[BIT_BUS_VOLTAGE_LIMIT_STATE] = 1'b1;
		else if (code >= CLIM_LO && code <= CLIM_HI)
			b[BIT_CLIM_LO + 5'(code - CLIM_LO)] = 1'b1;
		return b;
	endfunction : code_to_bit

	// source pick for one function input
	function automatic logic pick_src(
		input logic [8:0] code,
		input logic [5:0] term,
		input logic       mfi,
		input logic       hit,
		input logic       flt,
		input logic       tech
	);
		logic r;
		r = 1'b0;
		if (code >= SRC_TERM1 && code <= SRC_TERM6)
			r = term[3'(code - SRC_TERM1)];
		else
			unique case (code)
				SRC_ON:    r = 1'b1;
				SRC_OFF:   r = 1'b0;
				SRC_TECH:  r = tech;
				SRC_FAULT: r = flt;
				SRC_MFI:   r = mfi;
				SRC_MASK:  r = hit;
				default:   r = 1'b0;
			endcase
		return r;
	endfunction : pick_src

	////////////////////////////////////////////////////////////////////////
	// apb decode
	logic               pready_ff;
	logic               pslverr_ff;
	logic [31:0]        prdata_ff;
	logic               setup;
	logic               wr_en;
	logic               addr_ok;
	logic [31:0]        rd_val;

	logic [31:0]        mask_ff;
	logic [31:0]        cond_ff;
	logic               mask_hit_ff;
	logic [15:0]        udc_ref_ff;
	logic [2:0]         mfi_mode_ff;
	logic [9:0]         config_ff;
	logic [11:0]        remote_ff;
	logic [1:0]         irq_stat_ff;
	logic [1:0]         irq_mask_ff;
	logic               irq_ff;
	logic               fault_d_ff;
	logic               hit_d_ff;
	logic [8:0]         sel_ff [NUM_SEL];
	logic [NUM_SEL-1:0] func_ff;
	logic [6:0]         sync1_ff;
	logic [6:0]         sync2_ff;
	logic               rel_ff;
	logic [5:0]         term_src;
	logic               mfi_src;
	logic               tech_src;
	logic [31:0]        cond_now;
	logic [7:0]         cmd;
	logic [1:0]         irq_set;

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
	assign cmd   = pwdata[7:0];

	always_comb
	begin
		addr_ok = (paddr[1:0] == 2'b00) && (paddr <= REG_SEL_OUT ||
			(paddr >= REG_SEL_BASE && paddr < REG_SEL_BASE + 8'(4 * NUM_SEL)));
		rd_val = '0;
		unique case (paddr)
			REG_MASK:     rd_val = mask_ff;
			REG_COND:     rd_val = cond_ff;
			REG_UDC_REF:  rd_val = {16'h0000, udc_ref_ff};
			REG_MFI_MODE: rd_val = {29'h0, mfi_mode_ff};
			REG_CONFIG:   rd_val = {22'h0, config_ff};
			REG_REMOTE:   rd_val = {20'h0, remote_ff};
			REG_IRQ_STAT: rd_val = {30'h0, irq_stat_ff};
			REG_IRQ_MASK: rd_val = {30'h0, irq_mask_ff};
			REG_SEL_OUT:  rd_val = {28'h0, func_ff};
			default:
			begin
				if (paddr >= REG_SEL_BASE && addr_ok)
					rd_val = {23'h0, sel_ff[2'(paddr[7:2] - REG_SEL_BASE[7:2])]};
			end
		endcase
	end

	// no wait state: answer is registered during setup
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end
		else
		begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !addr_ok;
			if (setup)
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			udc_ref_ff  <= UDC_REF_RST;
			mfi_mode_ff <= '0;
			config_ff   <= CFG_RESET;
			remote_ff   <= '0;
			irq_mask_ff <= '0;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				REG_UDC_REF:  udc_ref_ff  <= pwdata[15:0];
				REG_MFI_MODE: mfi_mode_ff <= pwdata[2:0];
				REG_CONFIG:   config_ff   <= pwdata[9:0];
				REG_REMOTE:   remote_ff   <= pwdata[11:0];
				REG_IRQ_MASK: irq_mask_ff <= pwdata[1:0];
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// warning mask edits
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			mask_ff <= MASK_RESET;
		else if (wr_en && paddr == REG_MASK_CMD)
		begin
			if (cmd == CMD_ALL)
				mask_ff <= BULK_ALL;
			else if (cmd == CMD_WARN)
				mask_ff <= mask_ff | BULK_WARN;
			else if (cmd == CMD_CTRL)
				mask_ff <= mask_ff | BULK_CTRL;
			else if (cmd >= CMD_RM_LO && cmd <= CMD_RM_HI)
				mask_ff <= mask_ff & ~code_to_bit(cmd - CMD_REMOVE);
			else
				mask_ff <= mask_ff | code_to_bit(cmd);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// live conditions in mask layout
	always_comb
	begin
		cond_now       = '0;
		cond_now[15:0] = conds.warn;
		cond_now[16]   = conds.bus_voltage_dynamic_state;
		cond_now[17]   = conds.mains_loss_shutdown_state;
		cond_now[18]   = conds.mains_loss_regulation_state;
		cond_now[31]   = bus_voltage > udc_ref_ff;
		cond_now[20]   = conds.boost;
		cond_now[21]   = conds.current_limited;
		cond_now[22]   = conds.torque_limited;
		cond_now[23]   = conds.torque_ctrl;
		cond_now[24]   = conds.ramp_stop;
		cond_now[25]   = conds.long_overload_reached && conds.icl_active;
		cond_now[26]   = conds.short_overload_reached && conds.icl_active;
		cond_now[27]   = conds.heatsink_limit;
		cond_now[28]   = conds.motor_temp_limit;
		cond_now[29]   = conds.freq_limit;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cond_ff     <= '0;
			mask_hit_ff <= 1'b0;
		end
		else
		begin
			cond_ff     <= cond_now;
			mask_hit_ff <= |(cond_ff & mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and source conditioning
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			rel_ff   <= 1'b0;
		end
		else
		begin
			sync1_ff <= {multifunction_input_digital, terminal_input};
			sync2_ff <= sync1_ff;
			rel_ff   <= sync2_ff[0];
		end
	end

	always_comb
	begin
		term_src[0] = sync2_ff[0];
		for (int i = 1; i < 6; i++)
			term_src[i] = remote_ff[5 + i] ? remote_ff[i - 1] : sync2_ff[i];
		mfi_src  = remote_ff[11] ? remote_ff[5] :
			(mfi_mode_ff == MFI_DIGITAL) && sync2_ff[6];
		tech_src = tech_start && (config_ff == CFG_TECH_A || config_ff == CFG_TECH_B);
	end

	////////////////////////////////////////////////////////////////////////
	// per-function selectors
	generate
		for (genvar g = 0; g < NUM_SEL; g++)
		begin : gen_sel
			always_ff @(posedge sys_clk)
			begin
				if (rst)
				begin
					sel_ff[g]  <= SEL_RESET;
					func_ff[g] <= 1'b0;
				end
				else
				begin
					if (wr_en && paddr == REG_SEL_BASE + 8'(4 * g))
						sel_ff[g] <= pwdata[8:0];
					func_ff[g] <= pick_src(sel_ff[g], term_src, mfi_src,
						mask_hit_ff, fault, tech_src);
				end
			end

			const_on_a : assert property (@(posedge sys_clk) disable iff (rst)
				sel_ff[g] == SRC_ON |=> func_ff[g])
				else $error("constant on source not high");

			mfi_gate_a : assert property (@(posedge sys_clk) disable iff (rst)
				sel_ff[g] == SRC_MFI && !remote_ff[11] && mfi_mode_ff != MFI_DIGITAL
				|=> !func_ff[g])
				else $error("multifunction input passed outside digital mode");

			hit_route_a : assert property (@(posedge sys_clk) disable iff (rst)
				sel_ff[g] == SRC_MASK |=> func_ff[g] == $past(mask_hit_ff))
				else $error("mask source does not follow mask output");

			tech_gate_a : assert property (@(posedge sys_clk) disable iff (rst)
				sel_ff[g] == SRC_TECH && config_ff != CFG_TECH_A && config_ff != CFG_TECH_B
				|=> !func_ff[g])
				else $error("tech start passed in wrong configuration");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// interrupts: mask output rise and fault rise, write one to clear
	assign irq_set = {fault && !fault_d_ff, mask_hit_ff && !hit_d_ff};

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			irq_stat_ff <= '0;
			fault_d_ff  <= 1'b0;
			hit_d_ff    <= 1'b0;
			irq_ff      <= 1'b0;
		end
		else
		begin
			fault_d_ff <= fault;
			hit_d_ff   <= mask_hit_ff;
			if (wr_en && paddr == REG_IRQ_STAT)
				irq_stat_ff <= (irq_stat_ff & ~pwdata[1:0]) | irq_set;
			else
				irq_stat_ff <= irq_stat_ff | irq_set;
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign func_out     = func_ff;
	assign ctrl_release = rel_ff;
	assign mask_hit     = mask_hit_ff;
	assign irq          = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	mask_add_a : assert property (@(posedge sys_clk) disable iff (rst)
		wr_en && paddr == REG_MASK_CMD && cmd >= WARN_LO && cmd <= CLIM_HI
		|=> (mask_ff & $past(code_to_bit(cmd))) == $past(code_to_bit(cmd)))
		else $error("added condition not in mask");

	mask_keep_a : assert property (@(posedge sys_clk) disable iff (rst)
		wr_en && paddr == REG_MASK_CMD && cmd == CMD_NONE |=> $stable(mask_ff))
		else $error("no change code altered mask");

	mask_remove_a : assert property (@(posedge sys_clk) disable iff (rst)
		wr_en && paddr == REG_MASK_CMD && cmd >= CMD_RM_LO && cmd <= CMD_RM_HI
		|=> mask_ff == ($past(mask_ff) & ~$past(code_to_bit(cmd - CMD_REMOVE))))
		else $error("remove code disturbed mask");

	bulk_all_a : assert property (@(posedge sys_clk) disable iff (rst)
		wr_en && paddr == REG_MASK_CMD && cmd == CMD_ALL |=> mask_ff == BULK_ALL)
		else $error("activate all failed");

	udc_limit_a : assert property (@(posedge sys_clk) disable iff (rst)
		##1 cond_ff[BIT_BUS_VOLTAGE_LIMIT_STATE] == $past(bus_voltage > udc_ref_ff))
		else $error("bus limit condition wrong");

	overload_a : assert property (@(posedge sys_clk) disable iff (rst)
		!conds.icl_active |=> !cond_ff[25] && !cond_ff[26])
		else $error("overload limit without current limiting");

	hit_or_a : assert property (@(posedge sys_clk) disable iff (rst)
		##1 mask_hit_ff == |($past(cond_ff) & $past(mask_ff)))
		else $error("mask output not or of masked conditions");

endmodule : wms_top

// file: testbench/testbench.sv
// self-checking bench for the warning mask and signal selector
`timescale 1ns/100ps
module testbench
	import wms_pkg::*;
;
	typedef struct packed {logic [7:0] code; logic [31:0] exp;} wms_mrow_t;
	typedef struct packed {logic [8:0] code; logic exp;} wms_srow_t;
	logic               sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic               multifunction_input_digital, fault, tech_start, ctrl_release, mask_hit, irq, rel_seen;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd, ce;
	logic [5:0]         terminal_input;
	logic [15:0]        bus_voltage;
	logic [29:0]        cin;
	wms_cond_t          conds;
	logic [NUM_SEL-1:0] func_out, func_seen;
	int                 n_mismatch, num_checks;
	int                 pos [14] = '{29, 28, 27, 0, 26, 25, 24, 23, 22, 21, 20, 18, 17, 16};
	wms_mrow_t mrows [16] = '{'{8'h00, 32'h0000_0000}, '{8'h0A, 32'h0000_0001}, '{8'h19, 32'h0000_8001},
		'{8'h1E, 32'h0001_8001}, '{8'h21, 32'h8001_8001}, '{8'h22, 32'h8011_8001}, '{8'h2B, 32'hA011_8001},
		'{8'h6E, 32'hA011_8000}, '{8'h85, 32'h2011_8000}, '{8'h8F, 32'h0011_8000}, '{8'h65, 32'h0011_8000},
		'{8'h02, 32'h0011_FFFF}, '{8'h7D, 32'h0011_7FFF}, '{8'h03, 32'hFFFF_7FFF}, '{8'h2C, 32'hFFFF_7FFF},
		'{8'h01, 32'hFFFF_FFFF}};
	wms_srow_t srows [13] = '{'{9'h006, 1'b1}, '{9'h007, 1'b0}, '{9'h046, 1'b1}, '{9'h047, 1'b0},
		'{9'h048, 1'b0}, '{9'h049, 1'b1}, '{9'h04A, 1'b0}, '{9'h04B, 1'b1}, '{9'h03D, 1'b1},
		'{9'h00D, 1'b0}, '{9'h04C, 1'b0}, '{9'h09D, 1'b0}, '{9'h1FF, 1'b0}};

	wms_top wms_top_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.terminal_input(terminal_input), .multifunction_input_digital(multifunction_input_digital),
		.conds(conds), .bus_voltage(bus_voltage), .fault(fault), .tech_start(tech_start),
		.func_out(func_out), .ctrl_release(ctrl_release), .mask_hit(mask_hit), .irq(irq));
	wms_drive_model wms_drive_model_inst (.sys_clk(sys_clk), .rst(rst), .func_out(func_out),
		.ctrl_release(ctrl_release), .func_seen_ff(func_seen), .release_seen_ff(rel_seen));

	always #10 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	task test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	// one apb transfer, holding the request until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task do_reset();
		rst <= 1'b1;
		tick(8);
		chk({pready, func_out, mask_hit, irq, ctrl_release}, '0);
		rst <= 1'b0;
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		n_mismatch++;
		test_done();
	end

	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		terminal_input = 6'b101001;
		multifunction_input_digital = 1'b1;
		conds = '0;
		bus_voltage = 16'h0000;
		fault = 1'b1;
		tech_start = 1'b1;
		n_mismatch = 0;
		num_checks = 0;
		do_reset();
		rdchk(REG_MASK, MASK_RESET);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, REG_MASK_CMD, {24'h0, mrows[i].code});
			rdchk(REG_MASK, mrows[i].exp);
		end
		for (int i = 0; i < 13; i++)
		begin
			apb(1'b1, REG_SEL_BASE + 8'(4 * (i % 4)), {23'h0, srows[i].code});
			tick(5);
			chk(func_seen[i % 4], srows[i].exp);
		end
		chk(rel_seen, 1'b1);
		apb(1'b1, REG_CONFIG, {22'h0, CFG_TECH_A});
		apb(1'b1, REG_SEL_BASE, 32'h0000_000D);
		apb(1'b1, REG_MFI_MODE, 32'h0000_0003);
		apb(1'b1, REG_SEL_BASE + 8'h04, 32'h0000_004C);
		apb(1'b1, REG_SEL_BASE + 8'h08, 32'h0000_0047);
		apb(1'b1, REG_REMOTE, 32'h0000_0041);
		tick(5);
		chk(func_seen[1:0], 2'b11);
		rdchk(REG_SEL_OUT, 32'h0000_0007);
		chk(func_out[2], 1'b1);
		apb(1'b1, REG_CONFIG, {22'h0, CFG_TECH_B});
		apb(1'b1, REG_REMOTE, 32'h0000_0841);
		tick(5);
		chk(func_seen[1:0], 2'b01);
		do_reset();
		rdchk(REG_MASK, MASK_RESET);
		rdchk(REG_SEL_BASE, {23'h0, SEL_RESET});
		apb(1'b1, REG_MASK_CMD, 32'h0000_0002);
		apb(1'b1, REG_MASK_CMD, 32'h0000_0021);
		apb(1'b1, REG_SEL_BASE + 8'h0C, 32'h0000_009D);
		apb(1'b1, REG_UDC_REF, 32'h0000_03E8);
		for (int i = 0; i < 30; i++)
		begin
			cin = (30'h1 << i) | 30'h8;
			ce = (i >= 14) ? 32'h1 << (i - 14) : (i == 3) ? 32'h0 : 32'h1 << pos[i];
			conds <= cin;
			tick(5);
			chk(mask_hit, |(ce & 32'h8000_FFFF));
			chk(func_seen[3], |(ce & 32'h8000_FFFF));
			rdchk(REG_COND, ce);
		end
		conds <= 30'h20;
		tick(3);
		rdchk(REG_COND, 32'h0);
		conds <= '0;
		bus_voltage <= 16'h03E8;
		tick(3);
		rdchk(REG_COND, 32'h0);
		bus_voltage <= 16'h03E9;
		tick(3);
		rdchk(REG_COND, 32'h8000_0000);
		chk(mask_hit, 1'b1);
		apb(1'b1, REG_MASK, 32'h0);
		rdchk(REG_MASK, 32'h8000_FFFF);
		rdchk(REG_MASK_CMD, 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		fault <= 1'b0;
		bus_voltage <= 16'h0000;
		tick(4);
		apb(1'b1, REG_IRQ_STAT, 32'h3);
		rdchk(REG_IRQ_STAT, 32'h0);
		fault <= 1'b1;
		tick(3);
		rdchk(REG_IRQ_STAT, 32'h2);
		chk(irq, 1'b0);
		apb(1'b1, REG_IRQ_MASK, 32'h2);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, REG_IRQ_STAT, 32'h2);
		tick(2);
		chk(irq, 1'b0);
		rdchk(REG_IRQ_STAT, 32'h0);
		bus_voltage <= 16'h03E9;
		tick(3);
		rdchk(REG_IRQ_STAT, 32'h1);
		test_done();
	end
endmodule : testbench

// file: testbench/wms_drive_model.sv
// drive function model that consumes the selected control signals
`timescale 1ns/100ps
module wms_drive_model
	import wms_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic [NUM_SEL-1:0] func_out,
	input  wire logic               ctrl_release,
	output logic      [NUM_SEL-1:0] func_seen_ff,
	output logic                    release_seen_ff
);
	// each function input latches its control level once a clock
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			func_seen_ff    <= '0;
			release_seen_ff <= 1'b0;
		end
		else
		begin
			func_seen_ff    <= func_out;
			release_seen_ff <= ctrl_release;
		end
	end
endmodule : wms_drive_model
